//--- include/avcmv_pkg.sv
// avcmv_pkg: constants shared by the motion-vector and weight record packer.
// assumes a 32-bit apb register bus and dword-wide record output.
package avcmv_pkg;
	// record size values as presented with a macroblock
	localparam logic [5:0] REC_SIZE_0 = 6'h00;
	localparam logic [5:0] REC_SIZE_2 = 6'h02;
	localparam logic [5:0] REC_SIZE_8 = 6'h08;
	localparam logic [5:0] REC_SIZE_16 = 6'h10;
	localparam logic [5:0] REC_SIZE_32 = 6'h20;
	// dword counts of the motion vector block per record size
	localparam logic [5:0] MV_DW_S2 = 6'h04;
	localparam logic [5:0] MV_DW_S8 = 6'h08;
	localparam logic [5:0] MV_DW_S16 = 6'h10;
	localparam logic [5:0] MV_DW_S32 = 6'h20;
	// dword counts of the weight block
	localparam logic [5:0] WO_DW_SMALL = 6'h04;
	localparam logic [5:0] WO_DW_BIG = 6'h10;
	// weighting selector value meaning implicit b weights
	localparam logic [1:0] SEL_IMPLICIT = 2'h2;
	// whole-macroblock types used by record size 2
	localparam logic [1:0] WHOLE_LIST0 = 2'h1;
	localparam logic [1:0] WHOLE_LIST1 = 2'h2;
	localparam logic [1:0] WHOLE_BIPRED = 2'h3;
	// macroblock partition shapes and 8x8 sub-partition shapes
	localparam logic [1:0] PART_16X16 = 2'h0;
	localparam logic [1:0] PART_16X8 = 2'h1;
	localparam logic [1:0] PART_8X16 = 2'h2;
	localparam logic [1:0] PART_8X8 = 2'h3;
	localparam logic [1:0] SUB_8X8 = 2'h0;
	localparam logic [1:0] SUB_8X4 = 2'h1;
	localparam logic [1:0] SUB_4X8 = 2'h2;
	localparam logic [1:0] SUB_4X4 = 2'h3;
	// apb register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	// control bits: 0 accept macroblocks, 1 emit weight-is-128 flags
	localparam int CTRL_ENABLE = 0;
	localparam int CTRL_FLAG128 = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	// status bits: 0 busy, 1 sticky unsupported record size
	localparam int STAT_BUSY = 0;
	localparam int STAT_BAD_SIZE = 1;
	typedef enum logic [1:0] {
		S_IDLE,
		S_MV,
		S_WO
	} avcmv_state_t;
endpackage : avcmv_pkg

//--- logic/avcmv_mv_expand.sv
// avcmv_mv_expand: expands partition vectors onto sixteen 4x4 blocks.
// assumes each partition's vector sits at its top-left 4x4 block index,
// with block k = 8x8 quadrant k[3:2] and raster sub-block k[1:0].
`timescale 1ns/1ps
module avcmv_mv_expand (
	input wire logic [1:0] part_shape,
	input wire logic [7:0] sub_shape,
	input wire logic [255:0] horz_l0,
	input wire logic [255:0] vert_l0,
	input wire logic [255:0] horz_l1,
	input wire logic [255:0] vert_l1,
	input wire logic [15:0] pred_l0,
	input wire logic [15:0] pred_l1,
	output logic [511:0] filled_l0,
	output logic [511:0] filled_l1,
	output logic [15:0] has_l0,
	output logic [15:0] has_l1
);
	for (genvar k = 0; k < 16; k++) begin : g_blk
		localparam logic [3:0] KB = 4'(k);
		localparam logic [3:0] BASE = {KB[3:2], 2'b00};
		logic [3:0] src;
		logic [31:0] raw0;
		logic [31:0] raw1;
		always_comb begin
			case (part_shape)
				avcmv_pkg::PART_16X16: src = 4'h0;
				avcmv_pkg::PART_16X8: src = KB[3] ? 4'h8 : 4'h0;
				avcmv_pkg::PART_8X16: src = KB[2] ? 4'h4 : 4'h0;
				default: begin
					case (sub_shape[2 * KB[3:2] +: 2])
						avcmv_pkg::SUB_8X8: src = BASE;
						avcmv_pkg::SUB_8X4: src = BASE | {2'b00, KB[1], 1'b0};
						avcmv_pkg::SUB_4X8: src = BASE | {3'b000, KB[0]};
						default: src = KB;
					endcase
				end
			endcase
		end
		// vertical in the upper half of each vector dword
		assign raw0 = {vert_l0[16 * src +: 16], horz_l0[16 * src +: 16]};
		assign raw1 = {vert_l1[16 * src +: 16], horz_l1[16 * src +: 16]};
		assign filled_l0[32 * k +: 32] = pred_l0[src] ? raw0 : raw1;
		assign filled_l1[32 * k +: 32] = pred_l1[src] ? raw1 : raw0;
		assign has_l0[k] = pred_l0[src];
		assign has_l1[k] = pred_l1[src];
	end
endmodule : avcmv_mv_expand

//--- logic/avcmv_packer.sv
// avcmv_packer: accepts one macroblock description and streams its motion
// vector block, then its weight/offset block when weight_present is set, as dwords.
// assumes an apb3 master and a dword sink with valid/ready handshake.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module avcmv_packer (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mb_valid,
	output logic mb_ready,
	input wire logic [5:0] vector_record_size,
	input wire logic [1:0] weighting_selector,
	input wire logic weight_present,
	input wire logic [1:0] whole_mb_type,
	input wire logic [1:0] part_shape,
	input wire logic [7:0] sub_shape,
	input wire logic [255:0] horizontal_component_list0,
	input wire logic [255:0] vertical_component_list0,
	input wire logic [255:0] horizontal_component_list1,
	input wire logic [255:0] vertical_component_list1,
	input wire logic [15:0] pred_list0,
	input wire logic [15:0] pred_list1,
	input wire logic [31:0] luma_weight_list0,
	input wire logic [31:0] luma_offset_list0,
	input wire logic [31:0] luma_weight_list1,
	input wire logic [31:0] luma_offset_list1,
	input wire logic [63:0] cb_weight_offset_list0,
	input wire logic [63:0] cb_weight_offset_list1,
	input wire logic [63:0] cr_weight_offset_list0,
	input wire logic [63:0] cr_weight_offset_list1,
	input wire logic [107:0] implicit_weight_list0,
	input wire logic [107:0] implicit_weight_list1,
	input wire logic [15:0] weight128_flags,
	output logic out_valid,
	input wire logic out_ready,
	output logic [31:0] out_data,
	output logic out_is_weight,
	output logic out_last
);
	localparam int PL_W = 6 + 2 + 1 + 2 + 2 + 8 + 4 * 256 + 2 * 16
		+ 4 * 32 + 4 * 64 + 2 * 108 + 16;
	logic [PL_W-1:0] pl_d;
	logic [PL_W-1:0] pl_q;
	logic [5:0] size_q;
	logic [1:0] sel_q;
	logic wo_q;
	logic [1:0] whole_q;
	logic [1:0] part_q;
	logic [7:0] sub_q;
	logic [255:0] h0_q;
	logic [255:0] v0_q;
	logic [255:0] h1_q;
	logic [255:0] v1_q;
	logic [15:0] p0_q;
	logic [15:0] p1_q;
	logic [31:0] lw0_q;
	logic [31:0] lo0_q;
	logic [31:0] lw1_q;
	logic [31:0] lo1_q;
	logic [63:0] cb0_q;
	logic [63:0] cb1_q;
	logic [63:0] cr0_q;
	logic [63:0] cr1_q;
	logic [107:0] iw0_q;
	logic [107:0] iw1_q;
	logic [15:0] f128_q;
	logic accept;
	logic size_ok;
	avcmv_pkg::avcmv_state_t state_d;
	avcmv_pkg::avcmv_state_t state_q;
	logic [5:0] idx_d;
	logic [5:0] idx_q;
	logic mb_ready_d;
	logic mb_ready_q;
	logic out_valid_d;
	logic out_valid_q;
	logic [31:0] out_data_d;
	logic [31:0] out_data_q;
	logic out_wt_d;
	logic out_wt_q;
	logic out_last_d;
	logic out_last_q;
	logic [5:0] out_idx_d;
	logic [5:0] out_idx_q;
	logic slot_free;
	logic [5:0] mv_count;
	logic [5:0] wo_count;
	logic [511:0] filled_l0;
	logic [511:0] filled_l1;
	logic [15:0] has_l0;
	logic [15:0] has_l1;
	logic [3:0] mv_blk;
	logic mv_list1;
	logic mv_zero;
	logic [31:0] mv_dword;
	logic [31:0] wo_dword;
	logic [1:0] ctrl_d;
	logic [1:0] ctrl_q;
	logic bad_d;
	logic bad_q;
	logic [15:0] count_d;
	logic [15:0] count_q;
	logic [31:0] prdata_d;
	logic [31:0] prdata_q;
	logic pready_d;
	logic pready_q;
	logic pslverr_d;
	logic pslverr_q;
	logic mapped;
	logic wr_fire;
	logic out_s2_d;
	logic out_s2_q;
	logic out_imp_d;
	logic out_imp_q;

	// capture the whole description so the source may move on at once
	assign accept = mb_valid && mb_ready_q;
	assign pl_d = accept ? {vector_record_size, weighting_selector,
		weight_present, whole_mb_type, part_shape, sub_shape,
		horizontal_component_list0, vertical_component_list0,
		horizontal_component_list1, vertical_component_list1,
		pred_list0, pred_list1, luma_weight_list0, luma_offset_list0,
		luma_weight_list1, luma_offset_list1, cb_weight_offset_list0,
		cb_weight_offset_list1, cr_weight_offset_list0,
		cr_weight_offset_list1, implicit_weight_list0,
		implicit_weight_list1, weight128_flags} : pl_q;
	assign {size_q, sel_q, wo_q, whole_q, part_q, sub_q, h0_q, v0_q, h1_q,
		v1_q, p0_q, p1_q, lw0_q, lo0_q, lw1_q, lo1_q, cb0_q, cb1_q, cr0_q,
		cr1_q, iw0_q, iw1_q, f128_q} = pl_q;

	always_comb begin
		case (vector_record_size)
			avcmv_pkg::REC_SIZE_2, avcmv_pkg::REC_SIZE_8,
			avcmv_pkg::REC_SIZE_16, avcmv_pkg::REC_SIZE_32: size_ok = 1'b1;
			default: size_ok = 1'b0;
		endcase
		case (size_q)
			avcmv_pkg::REC_SIZE_2: mv_count = avcmv_pkg::MV_DW_S2;
			avcmv_pkg::REC_SIZE_8: mv_count = avcmv_pkg::MV_DW_S8;
			avcmv_pkg::REC_SIZE_16: mv_count = avcmv_pkg::MV_DW_S16;
			default: mv_count = avcmv_pkg::MV_DW_S32;
		endcase
		wo_count = (size_q == avcmv_pkg::REC_SIZE_2) ? avcmv_pkg::WO_DW_SMALL
			: avcmv_pkg::WO_DW_BIG;
	end

	avcmv_mv_expand u_expand (
		.part_shape(part_q),
		.sub_shape(sub_q),
		.horz_l0(h0_q),
		.vert_l0(v0_q),
		.horz_l1(h1_q),
		.vert_l1(v1_q),
		.pred_l0(p0_q),
		.pred_l1(p1_q),
		.filled_l0(filled_l0),
		.filled_l1(filled_l1),
		.has_l0(has_l0),
		.has_l1(has_l1)
	);

	// map dword index onto a 4x4 block and a list
	always_comb begin
		mv_zero = 1'b0;
		case (size_q)
			avcmv_pkg::REC_SIZE_2: begin
				mv_blk = 4'h0;
				mv_list1 = idx_q[0];
				mv_zero = idx_q[1];
			end
			avcmv_pkg::REC_SIZE_8: begin
				mv_blk = {idx_q[2:1], 2'b00};
				mv_list1 = idx_q[0];
			end
			avcmv_pkg::REC_SIZE_16: begin
				mv_blk = idx_q[3:0];
				mv_list1 = 1'b0;
			end
			default: begin
				mv_blk = idx_q[4:1];
				mv_list1 = idx_q[0];
			end
		endcase
		if (mv_zero)
			mv_dword = 32'h0000_0000;
		else if (mv_list1)
			mv_dword = filled_l1[32 * mv_blk +: 32];
		else
			mv_dword = filled_l0[32 * mv_blk +: 32];
	end

	avcmv_wo_pack u_wo (
		.idx(idx_q[3:0]),
		.size_is_2(size_q == avcmv_pkg::REC_SIZE_2),
		.selector(sel_q),
		.whole_type(whole_q),
		.part_shape(part_q),
		.blk_l0({has_l0[12], has_l0[8], has_l0[4], has_l0[0]}),
		.blk_l1({has_l1[12], has_l1[8], has_l1[4], has_l1[0]}),
		.flag_en(ctrl_q[avcmv_pkg::CTRL_FLAG128]),
		.luma_weight_list0(lw0_q),
		.luma_offset_list0(lo0_q),
		.luma_weight_list1(lw1_q),
		.luma_offset_list1(lo1_q),
		.cb_weight_offset_list0(cb0_q),
		.cb_weight_offset_list1(cb1_q),
		.cr_weight_offset_list0(cr0_q),
		.cr_weight_offset_list1(cr1_q),
		.implicit_weight_list0(iw0_q),
		.implicit_weight_list1(iw1_q),
		.weight128_flags(f128_q),
		.dword(wo_dword)
	);

	// sequencer; output slot refills only when empty or being drained
	assign slot_free = !out_valid_q || out_ready;
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		out_valid_d = out_valid_q && !out_ready;
		out_data_d = out_data_q;
		out_wt_d = out_wt_q;
		out_last_d = out_last_q;
		out_idx_d = out_idx_q;
		count_d = count_q;
		out_s2_d = out_s2_q;
		out_imp_d = out_imp_q;
		case (state_q)
			avcmv_pkg::S_IDLE: begin
				if (accept) begin
					count_d = count_q + 16'h0001;
					idx_d = 6'h00;
					// size 0 and unknown sizes leave nothing to send
					if (size_ok)
						state_d = avcmv_pkg::S_MV;
				end
			end
			avcmv_pkg::S_MV: begin
				if (slot_free) begin
					out_valid_d = 1'b1;
					out_data_d = mv_dword;
					out_wt_d = 1'b0;
					out_idx_d = idx_q;
					out_last_d = 1'b0;
					idx_d = idx_q + 6'h01;
					if (idx_q == mv_count - 6'h01) begin
						idx_d = 6'h00;
						if (wo_q) begin
							state_d = avcmv_pkg::S_WO;
						end else begin
							state_d = avcmv_pkg::S_IDLE;
							out_last_d = 1'b1;
						end
					end
				end
			end
			avcmv_pkg::S_WO: begin
				if (slot_free) begin
					out_valid_d = 1'b1;
					out_data_d = wo_dword;
					out_wt_d = 1'b1;
					out_idx_d = idx_q;
					out_last_d = 1'b0;
					idx_d = idx_q + 6'h01;
					if (idx_q == wo_count - 6'h01) begin
						state_d = avcmv_pkg::S_IDLE;
						out_last_d = 1'b1;
					end
				end
			end
			default: state_d = avcmv_pkg::S_IDLE;
		endcase
		// record attributes travel with the dword, as a new macroblock may
		// be captured while the previous last dword is still stalled
		if (slot_free && state_q != avcmv_pkg::S_IDLE) begin
			out_s2_d = size_q == avcmv_pkg::REC_SIZE_2;
			out_imp_d = sel_q == avcmv_pkg::SEL_IMPLICIT;
		end
		mb_ready_d = ctrl_q[avcmv_pkg::CTRL_ENABLE]
			&& state_d == avcmv_pkg::S_IDLE;
	end

	// apb slave: one wait-free access phase, errors on unmapped offsets
	assign wr_fire = psel && penable && pready_q && pwrite && !pslverr_q;
	always_comb begin
		mapped = paddr == avcmv_pkg::REG_CTRL
			|| paddr == avcmv_pkg::REG_STATUS
			|| paddr == avcmv_pkg::REG_COUNT;
		pready_d = psel && !penable;
		pslverr_d = psel && !penable && !mapped;
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			case (paddr)
				avcmv_pkg::REG_CTRL: prdata_d = {30'h0000_0000, ctrl_q};
				avcmv_pkg::REG_STATUS: prdata_d = {30'h0000_0000, bad_q,
					state_q != avcmv_pkg::S_IDLE || out_valid_q};
				avcmv_pkg::REG_COUNT: prdata_d = {16'h0000, count_q};
				default: prdata_d = 32'h0000_0000;
			endcase
		end
		ctrl_d = ctrl_q;
		if (wr_fire && paddr == avcmv_pkg::REG_CTRL)
			ctrl_d = pwdata[1:0];
		// write one clears; a new bad size in the same cycle wins
		bad_d = bad_q;
		if (wr_fire && paddr == avcmv_pkg::REG_STATUS
			&& pwdata[avcmv_pkg::STAT_BAD_SIZE])
			bad_d = 1'b0;
		if (accept && !size_ok && vector_record_size != avcmv_pkg::REC_SIZE_0)
			bad_d = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pl_q <= '0;
			state_q <= avcmv_pkg::S_IDLE;
			idx_q <= 6'h00;
			mb_ready_q <= 1'b0;
			out_valid_q <= 1'b0;
			out_data_q <= 32'h0000_0000;
			out_wt_q <= 1'b0;
			out_last_q <= 1'b0;
			out_idx_q <= 6'h00;
			count_q <= 16'h0000;
			ctrl_q <= avcmv_pkg::CTRL_RESET;
			bad_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			out_s2_q <= 1'b0;
			out_imp_q <= 1'b0;
		end else begin
			pl_q <= pl_d;
			state_q <= state_d;
			idx_q <= idx_d;
			mb_ready_q <= mb_ready_d;
			out_valid_q <= out_valid_d;
			out_data_q <= out_data_d;
			out_wt_q <= out_wt_d;
			out_last_q <= out_last_d;
			out_idx_q <= out_idx_d;
			count_q <= count_d;
			ctrl_q <= ctrl_d;
			bad_q <= bad_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			out_s2_q <= out_s2_d;
			out_imp_q <= out_imp_d;
		end
	end

	assign mb_ready = mb_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign out_is_weight = out_wt_q;
	assign out_last = out_last_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_size2_tail_zero;
		out_valid && !out_is_weight && out_s2_q
			&& out_idx_q[1] |-> out_data == 32'h0000_0000;
	endproperty
	a_size2_tail_zero: assert property (p_size2_tail_zero)
		else $error("size 2 vector tail not zero");
	property p_size2_last;
		out_valid && !out_is_weight && out_last
			&& out_s2_q |-> out_idx_q == 6'h03;
	endproperty
	a_size2_last: assert property (p_size2_last)
		else $error("size 2 vector block wrong length");
	property p_size16_map;
		state_q == avcmv_pkg::S_MV && slot_free
			&& size_q == avcmv_pkg::REC_SIZE_16
			|=> out_data == filled_l0[32 * out_idx_q[3:0] +: 32];
	endproperty
	a_size16_map: assert property (p_size16_map)
		else $error("size 16 dword not block list0 vector");
	property p_wo_big_last;
		out_valid && out_is_weight && out_last
			&& !out_s2_q |-> out_idx_q == 6'h0F;
	endproperty
	a_wo_big_last: assert property (p_wo_big_last)
		else $error("weight block not sixteen dwords");
	property p_explicit_resv;
		out_valid && out_is_weight && !out_imp_q
			&& out_idx_q[1:0] == 2'h3 |-> out_data[31:4] == 28'h000_0000;
	endproperty
	a_explicit_resv: assert property (p_explicit_resv)
		else $error("explicit reserved bits not zero");
	property p_implicit_fmt;
		out_valid && out_is_weight && out_imp_q
			|-> (out_idx_q[1:0] == 2'h3) ? out_data == 32'h0000_0000
			: (out_data[15:9] == {7{out_data[8]}}
			&& out_data[31:25] == {7{out_data[24]}});
	endproperty
	a_implicit_fmt: assert property (p_implicit_fmt)
		else $error("implicit weight dword malformed");
	property p_size0_silent;
		accept && vector_record_size == avcmv_pkg::REC_SIZE_0
			|=> state_q == avcmv_pkg::S_IDLE [*2];
	endproperty
	a_size0_silent: assert property (p_size0_silent)
		else $error("size 0 macroblock started a record");
	property p_wo_follows;
		state_q == avcmv_pkg::S_MV && slot_free && wo_q
			&& idx_q == mv_count - 6'h01
			|=> state_q == avcmv_pkg::S_WO && !out_last && idx_q == 6'h00;
	endproperty
	a_wo_follows: assert property (p_wo_follows)
		else $error("weight block did not follow vectors");
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_data);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output changed while stalled");
	c_size2: cover property (out_valid && out_ready && out_last
		&& size_q == avcmv_pkg::REC_SIZE_2);
	c_size32: cover property (out_valid && out_last && !out_is_weight
		&& size_q == avcmv_pkg::REC_SIZE_32);
	c_implicit: cover property (out_valid && out_is_weight && out_last
		&& sel_q == avcmv_pkg::SEL_IMPLICIT);
	c_stall: cover property (out_valid && !out_ready [*3]);
endmodule : avcmv_packer

//--- logic/avcmv_wo_pack.sv
// avcmv_wo_pack: builds one dword of the weight/offset block by index.
// assumes the per-8x8 inputs are stable while a record is emitted.
`timescale 1ns/1ps
module avcmv_wo_pack (
	input wire logic [3:0] idx,
	input wire logic size_is_2,
	input wire logic [1:0] selector,
	input wire logic [1:0] whole_type,
	input wire logic [1:0] part_shape,
	input wire logic [3:0] blk_l0,
	input wire logic [3:0] blk_l1,
	input wire logic flag_en,
	input wire logic [31:0] luma_weight_list0,
	input wire logic [31:0] luma_offset_list0,
	input wire logic [31:0] luma_weight_list1,
	input wire logic [31:0] luma_offset_list1,
	input wire logic [63:0] cb_weight_offset_list0,
	input wire logic [63:0] cb_weight_offset_list1,
	input wire logic [63:0] cr_weight_offset_list0,
	input wire logic [63:0] cr_weight_offset_list1,
	input wire logic [107:0] implicit_weight_list0,
	input wire logic [107:0] implicit_weight_list1,
	input wire logic [15:0] weight128_flags,
	output logic [31:0] dword
);
	logic [1:0] g;
	logic [1:0] sb;
	logic have0;
	logic have1;
	logic [8:0] iw0;
	logic [8:0] iw1;
	always_comb begin
		// weights follow the same spread as the binding-table indices
		g = idx[3:2];
		case (part_shape)
			avcmv_pkg::PART_16X16: sb = 2'h0;
			avcmv_pkg::PART_16X8: sb = g[1] ? 2'h2 : 2'h0;
			avcmv_pkg::PART_8X16: sb = g[0] ? 2'h1 : 2'h0;
			default: sb = g;
		endcase
		if (size_is_2) begin
			sb = 2'h0;
			have0 = whole_type != avcmv_pkg::WHOLE_LIST1;
			have1 = whole_type != avcmv_pkg::WHOLE_LIST0;
		end else begin
			have0 = blk_l0[sb];
			have1 = blk_l1[sb];
		end
		iw0 = 9'h000;
		iw1 = 9'h000;
		dword = 32'h0000_0000;
		if (selector == avcmv_pkg::SEL_IMPLICIT) begin
			// offsets dropped; 9-bit weights sign extended to 16 bits
			case (idx[1:0])
				2'h0: begin
					iw0 = implicit_weight_list0[27 * sb +: 9];
					iw1 = implicit_weight_list1[27 * sb +: 9];
				end
				2'h1: begin
					iw0 = implicit_weight_list0[27 * sb + 9 +: 9];
					iw1 = implicit_weight_list1[27 * sb + 9 +: 9];
				end
				default: begin
					iw0 = implicit_weight_list0[27 * sb + 18 +: 9];
					iw1 = implicit_weight_list1[27 * sb + 18 +: 9];
				end
			endcase
			if (!have0)
				iw0 = iw1;
			if (!have1)
				iw1 = iw0;
			if (idx[1:0] != 2'h3)
				dword = {{7{iw1[8]}}, iw1, {7{iw0[8]}}, iw0};
		end else begin
			case (idx[1:0])
				2'h0: dword = {
					have1 ? luma_offset_list1[8 * sb +: 8]
						: luma_offset_list0[8 * sb +: 8],
					have1 ? luma_weight_list1[8 * sb +: 8]
						: luma_weight_list0[8 * sb +: 8],
					have0 ? luma_offset_list0[8 * sb +: 8]
						: luma_offset_list1[8 * sb +: 8],
					have0 ? luma_weight_list0[8 * sb +: 8]
						: luma_weight_list1[8 * sb +: 8]};
				2'h1: dword = {
					have1 ? cb_weight_offset_list1[16 * sb +: 16]
						: cb_weight_offset_list0[16 * sb +: 16],
					have0 ? cb_weight_offset_list0[16 * sb +: 16]
						: cb_weight_offset_list1[16 * sb +: 16]};
				2'h2: dword = {
					have1 ? cr_weight_offset_list1[16 * sb +: 16]
						: cr_weight_offset_list0[16 * sb +: 16],
					have0 ? cr_weight_offset_list0[16 * sb +: 16]
						: cr_weight_offset_list1[16 * sb +: 16]};
				// only the flag nibble may be non-zero in the last dword
				default: dword = {28'h000_0000,
					flag_en ? weight128_flags[4 * sb +: 4] : 4'h0};
			endcase
		end
	end
endmodule : avcmv_wo_pack

//--- tb/avcmv_sink.sv
// avcmv_sink: dword consumer standing in for the reading kernel.
// assumes out_valid/out_data are held while out_ready is low.
`timescale 1ns/1ps
module avcmv_sink (
	input wire logic clock,
	input wire logic out_valid,
	input wire logic [31:0] out_data,
	input wire logic out_is_weight,
	input wire logic out_last,
	output logic out_ready
);
	logic [31:0] got[$];
	logic [1:0] tag[$];
	logic [1:0] cnt_q = 2'h0;
	// stalls one cycle in four so held data is exercised
	always @(posedge clock) begin
		cnt_q <= cnt_q + 2'h1;
		out_ready <= (cnt_q != 2'h2);
		if (out_valid && out_ready) begin
			got.push_back(out_data);
			tag.push_back({out_last, out_is_weight});
		end
	end
endmodule : avcmv_sink

//--- tb/tb_avcmv_packer.sv
// tb_avcmv_packer: sends macroblocks and apb cycles, checks the records.
// assumes avcmv_sink on the dword output.
`timescale 1ns/1ps
module tb_avcmv_packer;
	logic clock, rst, psel, penable, pwrite, pready, pslverr, mb_valid;
	logic mb_ready, weight_present, out_valid, out_ready, out_is_weight;
	logic out_last;
	logic [1:0] weighting_selector, whole_mb_type, part_shape;
	logic [5:0] vector_record_size;
	logic [7:0] paddr, sub_shape;
	logic [15:0] pred_list0, pred_list1, weight128_flags;
	logic [31:0] pwdata, prdata, out_data, luma_weight_list0, r;
	logic [31:0] luma_offset_list0, luma_weight_list1, luma_offset_list1;
	logic [63:0] cb_weight_offset_list0, cb_weight_offset_list1;
	logic [63:0] cr_weight_offset_list0, cr_weight_offset_list1;
	logic [107:0] implicit_weight_list0, implicit_weight_list1;
	logic [255:0] horizontal_component_list0, vertical_component_list0;
	logic [255:0] horizontal_component_list1, vertical_component_list1;
	logic [31:0] exp[$];
	logic e;
	// source 4x4 block of each block for quadrants 8x8, 8x4, 4x8, 4x4
	int src[16] = '{0, 0, 0, 0, 4, 4, 6, 6, 8, 9, 8, 9, 12, 13, 14, 15};
	int fails = 0;
	int samples_checked = 0;
	avcmv_packer uut (.*);
	avcmv_sink sink (.*);
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clock);
	endtask : apb
	task automatic send(input int nw);
		int n;
		sink.got.delete();
		sink.tag.delete();
		mb_valid <= 1;
		do @(posedge clock); while (mb_ready !== 1'b1);
		mb_valid <= 0;
		n = exp.size();
		repeat (4 * n + 8) @(posedge clock);
		chk(32'(sink.got.size()), 32'(n));
		foreach (exp[i])
			if (i < sink.got.size()) begin
				chk(sink.got[i], exp[i]);
				chk(32'(sink.tag[i]), {30'h0, i == n - 1, i >= n - nw});
			end
		exp.delete();
	endtask : send
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	initial begin
		#200000;
		fails++;
		finish_test();
	end
	initial begin
		rst = 1;
		{psel, penable, pwrite, mb_valid, paddr, pwdata} = '0;
		{weighting_selector, sub_shape, weight128_flags} = '0;
		{implicit_weight_list0, implicit_weight_list1} = '0;
		vector_record_size = avcmv_pkg::REC_SIZE_2;
		whole_mb_type = avcmv_pkg::WHOLE_LIST0;
		part_shape = avcmv_pkg::PART_16X16;
		weight_present = 1;
		pred_list0 = 16'hFFFF;
		pred_list1 = 16'h0000;
		luma_weight_list0 = 32'h11;
		luma_offset_list0 = 32'h22;
		luma_weight_list1 = 32'h33;
		luma_offset_list1 = 32'h44;
		cb_weight_offset_list0 = 64'h5566;
		cb_weight_offset_list1 = 64'h7788;
		cr_weight_offset_list0 = 64'h99AA;
		cr_weight_offset_list1 = 64'hBBCC;
		for (int k = 0; k < 16; k++) begin
			horizontal_component_list0[16*k+:16] = 16'(16'h0100 + k);
			vertical_component_list0[16*k+:16] = 16'(16'h0200 + k);
			horizontal_component_list1[16*k+:16] = 16'(16'h0300 + k);
			vertical_component_list1[16*k+:16] = 16'(16'h0400 + k);
		end
		repeat (16) @(posedge clock);
		rst <= 0;
		repeat (2) @(posedge clock);
		apb(1'b1, avcmv_pkg::REG_CTRL, 32'h3);
		apb(1'b0, avcmv_pkg::REG_CTRL, 32'h0);
		chk(r, 32'h3);
		weight128_flags <= 16'h000A;
		// whole macroblock, list 0 only, explicit weights
		exp = '{32'h02000100, 32'h02000100, 0, 0, 32'h22112211,
			32'h55665566, 32'h99AA99AA, 32'h0000000A};
		send(4);
		// 16x8 halves, each with one list missing
		vector_record_size <= avcmv_pkg::REC_SIZE_8;
		part_shape <= avcmv_pkg::PART_16X8;
		pred_list0 <= 16'hFF00;
		pred_list1 <= 16'h00FF;
		weight_present <= 0;
		for (int k = 0; k < 4; k++)
			repeat (2) exp.push_back(k < 2 ? 32'h04000300 : 32'h02080108);
		send(0);
		// macroblock split to 4x4 everywhere, list 0 on every block, list 1 still on the top half
		vector_record_size <= avcmv_pkg::REC_SIZE_16;
		part_shape <= avcmv_pkg::PART_8X8;
		sub_shape <= 8'hFF;
		pred_list0 <= 16'hFFFF;
		for (int k = 0; k < 16; k++)
			exp.push_back(32'h02000100 + 32'(k) * 32'h00010001);
		send(0);
		// b macroblock below 8x8 with mixed sub-shapes, implicit weights
		vector_record_size <= avcmv_pkg::REC_SIZE_32;
		sub_shape <= 8'hE4;
		weighting_selector <= avcmv_pkg::SEL_IMPLICIT;
		weight_present <= 1;
		implicit_weight_list0 <= {12{9'h101}};
		implicit_weight_list1 <= {12{9'h020}};
		foreach (src[k]) begin
			exp.push_back(32'h02000100 + src[k] * 32'h00010001);
			exp.push_back((src[k] < 8 ? 32'h04000300 : 32'h02000100)
				+ src[k] * 32'h00010001);
		end
		for (int g = 0; g < 16; g++)
			exp.push_back(g % 4 == 3 ? 32'h0 : g < 8 ? 32'h0020FF01
				: 32'hFF01FF01);
		send(16);
		// whole macroblock, list 1 only, no weights
		vector_record_size <= avcmv_pkg::REC_SIZE_2;
		part_shape <= avcmv_pkg::PART_16X16;
		weight_present <= 0;
		pred_list0 <= 16'h0000;
		pred_list1 <= 16'hFFFF;
		exp = '{32'h04000300, 32'h04000300, 0, 0};
		send(0);
		vector_record_size <= avcmv_pkg::REC_SIZE_0;
		send(0);
		vector_record_size <= 6'h05;
		send(0);
		apb(1'b0, avcmv_pkg::REG_STATUS, 32'h0);
		chk(r, 32'h2);
		apb(1'b1, avcmv_pkg::REG_STATUS, 32'h2);
		apb(1'b0, avcmv_pkg::REG_STATUS, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, avcmv_pkg::REG_COUNT, 32'h0);
		chk(r & 32'hFFFF, 32'h7);
		apb(1'b0, 8'hFC, 32'h0);
		chk(32'(e), 32'h1);
		apb(1'b1, avcmv_pkg::REG_CTRL, 32'h0);
		repeat (2) @(posedge clock);
		chk(32'(mb_ready), 32'h0);
		finish_test();
	end
endmodule : tb_avcmv_packer
